// ---- design/csm_consts.svh ----
// Constants for the context save list manager.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH
`define CSM_LINK_IDX 4'h0
`define CSM_W1_IDX 4'h1
`define CSM_SP_IDX 4'h2
`define CSM_RA_UP_IDX 4'h3
`define CSM_LAST_IDX 4'hF
`define CSM_NULL_PTR 20'h00000
`define CSM_PTR_MSB 19
`define CSM_UL_BIT 20
`define CSM_PIE_BIT 21
`define CSM_PREV_CPU_PRIORITY_LSB 22
`define CSM_PREV_CPU_PRIORITY_MSB 29
`define CSM_ISTK_BIT 9
`define CSM_CDC_MSB 6
`define CSM_EA_PAD 6'h00
`define CSM_WORD_BYTES 32'h00000004
`define CSM_AREA_MASK 32'hFFFFFFC0
`endif

// ---- design/csm_manager.sv ----
// Context save list manager: keeps the free and previous save-area lists.
// Assumes the core hands one context operation at a time with its image,
// and a word memory behind a req/ack port on the same clock.
module csm_manager
   import csm_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic op_valid_in,
   input wire csm_op_type op_code_in,
   input wire logic [31:0] op_pc_in,
   input wire logic [31:0] op_next_pc_in,
   input wire logic [31:0] op_ea_in,
   input wire logic [31:0] ctx_img_in [16],
   input wire logic [7:0] cur_cpu_priority_in,
   input wire logic irq_enable_flag_in,
   input wire logic [31:0] irq_stack_base_ptr_in,
   input wire logic cfg_wr_in,
   input wire logic [19:0] cfg_free_head_in,
   input wire logic [19:0] cfg_free_limit_in,
   input wire logic [31:0] cfg_context_info_in,
   input wire logic [31:0] cfg_status_in,
   input wire logic [31:0] cfg_stack_ptr_in,
   input wire logic [31:0] cfg_return_addr_in,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   output logic op_busy_out,
   output logic op_done_out,
   output logic ctx_valid_out,
   output logic [31:0] ctx_img_out [16],
   output logic free_list_depletion_trap_out,
   output logic free_list_underflow_trap_out,
   output logic call_stack_underflow_trap_out,
   output logic context_type_error_out,
   output logic call_depth_overflow_out,
   output logic irq_reenable_out,
   output logic [19:0] free_list_head_ptr_out,
   output logic [31:0] previous_context_info_out,
   output logic [31:0] processor_status_word_out,
   output logic [31:0] stack_pointer_out,
   output logic [31:0] return_address_out
);
`include "csm_consts.svh"
   csm_seq_if sq();
   csm_state_type state;
   csm_op_type op;
   logic [19:0] free_list_head_ptr;
   logic [19:0] free_list_limit_ptr;
   logic [31:0] previous_context_info;
   logic [31:0] processor_status_word;
   logic [31:0] stack_pointer_reg;
   logic [31:0] return_address_reg;
   logic [31:0] next_previous_buffer;
   logic [31:0] img [16];
   logic [31:0] area;
   logic depl;
   logic k_save, k_rest, k_store, k_load, k_upper, k_event;
   logic [19:0] previous_context_ptr;
   logic [6:0] cdc_m;
   logic [6:0] cdc_v;

   ////////////////////////////////////////////////////////////////////////
   // Address of a save area: offset steps by 64 bytes, segment on top
   function automatic logic [31:0] csm_ea(input logic [19:0] p);
      return {p[19:16], `CSM_EA_PAD, p[15:0], `CSM_EA_PAD};
   endfunction : csm_ea

   // True for operations whose image is the upper context
   function automatic logic op_upper(input csm_op_type o);
      return !(o inside {csm_op_begin_service, csm_op_save_lower,
         csm_op_restore_lower, csm_op_store_lower, csm_op_load_lower});
   endfunction : op_upper

   // Counter bits lie below the highest zero of the call depth field
   function automatic logic [6:0] cdc_mask(input logic [6:0] c);
      logic [6:0] m;
      m = 7'h00;
      for (int i = 0; i < 7; i++) begin
         if (!c[i]) m = 7'((8'h01 << i) - 8'h01);
      end
      return m;
   endfunction : cdc_mask

   ////////////////////////////////////////////////////////////////////////
   // Operation classes
   always_comb begin
      k_save = op inside {csm_op_call, csm_op_irq, csm_op_trap_sync,
         csm_op_trap_async, csm_op_system_call, csm_op_begin_service,
         csm_op_save_lower};
      k_rest = op inside {csm_op_call_return, csm_op_exception_return,
         csm_op_restore_lower};
      k_store = op inside {csm_op_store_lower, csm_op_store_upper};
      k_load = op inside {csm_op_load_lower, csm_op_load_upper};
      k_upper = op_upper(op);
      k_event = op inside {csm_op_irq, csm_op_trap_sync, csm_op_trap_async,
         csm_op_system_call};
   end
   assign previous_context_ptr = previous_context_info[`CSM_PTR_MSB:0];
   assign cdc_m = cdc_mask(processor_status_word[`CSM_CDC_MSB:0]);
   assign cdc_v = processor_status_word[`CSM_CDC_MSB:0];

   ////////////////////////////////////////////////////////////////////////
   // Sequencer launch: base, word span and direction in one pulse
   task automatic seq_go(input logic [31:0] b, input logic [3:0] f,
         input logic [3:0] l, input logic w);
      sq.start <= 1'b1;
      sq.base <= b;
      sq.first <= f;
      sq.last <= l;
      sq.wr <= w;
   endtask : seq_go

   ////////////////////////////////////////////////////////////////////////
   // Operation sequencing; for saves and restores the link word travels before the body
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= st_idle;
         op <= csm_op_call;
         op_busy_out <= 1'b0;
         op_done_out <= 1'b0;
         sq.start <= 1'b0;
         sq.wr <= 1'b0;
         sq.base <= 32'h00000000;
         sq.first <= 4'h0;
         sq.last <= 4'h0;
         area <= 32'h00000000;
         depl <= 1'b0;
      end else begin
         op_done_out <= 1'b0;
         sq.start <= 1'b0;
         case (state)
            st_idle: begin
               if (op_valid_in && !cfg_wr_in) begin
                  op <= op_code_in;
                  area <= op_ea_in & `CSM_AREA_MASK;
                  op_busy_out <= 1'b1;
                  state <= st_prep;
               end
            end
            st_prep: begin
               if ((k_save && free_list_head_ptr == `CSM_NULL_PTR) ||
                     (k_rest && previous_context_ptr == `CSM_NULL_PTR)) begin
                  op_done_out <= 1'b1;
                  op_busy_out <= 1'b0;
                  state <= st_idle;
               end else if (k_save) begin
                  seq_go(csm_ea(free_list_head_ptr), `CSM_LINK_IDX, `CSM_LINK_IDX,
                     1'b0);
                  area <= csm_ea(free_list_head_ptr);
                  depl <= (free_list_head_ptr == free_list_limit_ptr);
                  state <= st_link;
               end else if (k_rest) begin
                  seq_go(csm_ea(previous_context_ptr), `CSM_LINK_IDX, `CSM_LINK_IDX,
                     1'b0);
                  area <= csm_ea(previous_context_ptr);
                  state <= st_link;
               end else begin
                  seq_go(area, `CSM_LINK_IDX, `CSM_LAST_IDX, k_store);
                  state <= st_body;
               end
            end
            st_link: begin
               if (sq.done && k_save) begin
                  seq_go(area, `CSM_LINK_IDX, `CSM_LAST_IDX, 1'b1);
                  state <= st_body;
               end else if (sq.done && previous_context_info[`CSM_UL_BIT] != k_upper) begin
                  op_done_out <= 1'b1;
                  op_busy_out <= 1'b0;
                  state <= st_idle;
               end else if (sq.done) begin
                  state <= st_relink;
               end
            end
            st_relink: begin
               seq_go(area, `CSM_LINK_IDX, `CSM_LINK_IDX, 1'b1);
               state <= st_relink_wait;
            end
            st_relink_wait: begin
               if (sq.done) begin
                  seq_go(area, `CSM_W1_IDX, `CSM_LAST_IDX, 1'b0);
                  state <= st_body;
               end
            end
            st_body: begin
               if (sq.done) begin
                  op_done_out <= 1'b1;
                  op_busy_out <= 1'b0;
                  state <= st_idle;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pointers, status and trap pulses
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         free_list_head_ptr <= `CSM_NULL_PTR;
         free_list_limit_ptr <= `CSM_NULL_PTR;
         previous_context_info <= 32'h00000000;
         processor_status_word <= 32'h00000000;
         stack_pointer_reg <= 32'h00000000;
         return_address_reg <= 32'h00000000;
         next_previous_buffer <= 32'h00000000;
         free_list_depletion_trap_out <= 1'b0;
         free_list_underflow_trap_out <= 1'b0;
         call_stack_underflow_trap_out <= 1'b0;
         context_type_error_out <= 1'b0;
         call_depth_overflow_out <= 1'b0;
         irq_reenable_out <= 1'b0;
      end else begin
         free_list_depletion_trap_out <= 1'b0;
         free_list_underflow_trap_out <= 1'b0;
         call_stack_underflow_trap_out <= 1'b0;
         context_type_error_out <= 1'b0;
         call_depth_overflow_out <= 1'b0;
         irq_reenable_out <= 1'b0;
         if (state == st_idle && cfg_wr_in) begin
            free_list_head_ptr <= cfg_free_head_in;
            free_list_limit_ptr <= cfg_free_limit_in;
            previous_context_info <= cfg_context_info_in;
            processor_status_word <= cfg_status_in;
            stack_pointer_reg <= cfg_stack_ptr_in;
            return_address_reg <= cfg_return_addr_in;
         end
         if (state == st_prep) begin
            free_list_underflow_trap_out <= k_save && free_list_head_ptr == `CSM_NULL_PTR;
            call_stack_underflow_trap_out <= k_rest && previous_context_ptr == `CSM_NULL_PTR;
         end
         if (state == st_link && sq.done && k_save) begin
            // New chain head; the old info already sits in the link word
            previous_context_info[`CSM_PTR_MSB:0] <= free_list_head_ptr;
            previous_context_info[`CSM_UL_BIT] <= k_upper;
            free_list_head_ptr <= sq.rdata[`CSM_PTR_MSB:0];
            if (k_event) begin
               previous_context_info[`CSM_PIE_BIT] <= irq_enable_flag_in;
               previous_context_info[`CSM_PREV_CPU_PRIORITY_MSB:`CSM_PREV_CPU_PRIORITY_LSB] <= cur_cpu_priority_in;
               if (!processor_status_word[`CSM_ISTK_BIT]) begin
                  stack_pointer_reg <= irq_stack_base_ptr_in;
                  processor_status_word[`CSM_ISTK_BIT] <= 1'b1;
               end
            end
            if (op == csm_op_call && cdc_m != 7'h00) begin
               // Overflow traps; the count itself wraps to zero
               call_depth_overflow_out <= (cdc_v & cdc_m) == cdc_m;
               processor_status_word[`CSM_CDC_MSB:0] <=
                  (cdc_v & ~cdc_m) | ((cdc_v + 7'h01) & cdc_m);
            end
         end
         if (state == st_link && sq.done && k_rest) begin
            // Our own info flag types the head area; the link word types the one after
            context_type_error_out <= previous_context_info[`CSM_UL_BIT] != k_upper;
            next_previous_buffer <= sq.rdata;
         end
         if (state == st_relink_wait && sq.done) begin
            free_list_head_ptr <= previous_context_ptr;
            previous_context_info <= next_previous_buffer;
         end
         if (state == st_body && sq.done) begin
            if (k_save) begin
               free_list_depletion_trap_out <= depl;
               irq_reenable_out <= op == csm_op_begin_service;
               if (op == csm_op_trap_sync)
                  return_address_reg <= op_pc_in;
               else if (k_upper)
                  return_address_reg <= op_next_pc_in;
            end else if (!k_store) begin
               // Lower registers other than the return address and the link stay put
               if (k_load)
                  previous_context_info <= img[`CSM_LINK_IDX];
               if (k_upper) begin
                  processor_status_word <= img[`CSM_W1_IDX];
                  stack_pointer_reg <= img[`CSM_SP_IDX];
                  return_address_reg <= img[`CSM_RA_UP_IDX];
               end else begin
                  return_address_reg <= img[`CSM_W1_IDX];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Image buffer: captured at acceptance, so it holds pre-event values
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < 16; i++) img[i] <= 32'h00000000;
         ctx_valid_out <= 1'b0;
      end else begin
         ctx_valid_out <= 1'b0;
         if (state == st_idle && op_valid_in && !cfg_wr_in) begin
            for (int i = 0; i < 16; i++) img[i] <= ctx_img_in[i];
            img[`CSM_LINK_IDX] <= previous_context_info;
            if (op_upper(op_code_in)) begin
               img[`CSM_W1_IDX] <= processor_status_word;
               img[`CSM_SP_IDX] <= stack_pointer_reg;
               img[`CSM_RA_UP_IDX] <= return_address_reg;
            end else begin
               img[`CSM_W1_IDX] <= return_address_reg;
            end
         end
         if (state == st_link && sq.done && k_rest)
            img[`CSM_LINK_IDX] <= {12'h000, free_list_head_ptr};
         if (state == st_body && sq.rvalid)
            img[sq.ridx] <= sq.rdata;
         if (state == st_body && sq.done && !k_save && !k_store)
            ctx_valid_out <= 1'b1;
      end
   end
   assign sq.img = img;
   assign ctx_img_out = img;
   assign free_list_head_ptr_out = free_list_head_ptr;
   assign previous_context_info_out = previous_context_info;
   assign processor_status_word_out = processor_status_word;
   assign stack_pointer_out = stack_pointer_reg;
   assign return_address_out = return_address_reg;

   csm_seq u_seq (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .s(sq.seq),
      .mem_req_out(mem_req_out),
      .mem_we_out(mem_we_out),
      .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out),
      .mem_ack_in(mem_ack_in),
      .mem_rdata_in(mem_rdata_in)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_base_align;
      sq.start |-> sq.base[5:0] == 6'h00;
   endproperty
   a_base_align: assert property (p_base_align) else $error("area unaligned");
   property p_ea_map;
      state == st_prep && k_save && free_list_head_ptr != 20'h0 |=>
         sq.base == {free_list_head_ptr[19:16], 6'h0, free_list_head_ptr[15:0], 6'h0};
   endproperty
   a_ea_map: assert property (p_ea_map) else $error("bad area address");
   property p_link_first;
      state == st_prep && (k_save || k_rest) && !op_done_out |=>
         (op_done_out || (sq.start && !sq.wr && sq.last == 4'h0));
   endproperty
   a_link_first: assert property (p_link_first) else $error("link not first");
   property p_save_lists;
      state == st_link && sq.done && k_save |=>
         previous_context_ptr == $past(free_list_head_ptr) &&
         free_list_head_ptr == $past(sq.rdata[19:0]);
   endproperty
   a_save_lists: assert property (p_save_lists) else $error("save relink");
   property p_restore_lists;
      state == st_relink_wait && sq.done |=>
         free_list_head_ptr == $past(previous_context_ptr);
   endproperty
   a_restore_lists: assert property (p_restore_lists) else $error("restore relink");
   property p_type;
      state == st_link && sq.done && k_rest &&
         previous_context_info[`CSM_UL_BIT] != k_upper |=>
         context_type_error_out && state == st_idle;
   endproperty
   a_type: assert property (p_type) else $error("type trap missing");
   property p_depl;
      free_list_depletion_trap_out |-> op_done_out && depl;
   endproperty
   a_depl: assert property (p_depl) else $error("depletion trap");
   property p_istack;
      $rose(processor_status_word[`CSM_ISTK_BIT]) && $past(state) == st_link |->
         stack_pointer_reg == $past(irq_stack_base_ptr_in);
   endproperty
   a_istack: assert property (p_istack) else $error("stack switch");
   property p_xfer;
      state != st_idle && (k_store || k_load) |=> $stable(free_list_head_ptr);
   endproperty
   a_xfer: assert property (p_xfer) else $error("store moved head");
   c_save: cover property (state == st_body && sq.done && k_save);
   c_restore: cover property (ctx_valid_out && k_rest);
   c_type: cover property (context_type_error_out);
endmodule : csm_manager

// ---- design/csm_pkg.sv ----
// Types shared by the context save list manager and its word sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package csm_pkg;
   typedef enum logic [3:0] {
      csm_op_call, csm_op_irq, csm_op_trap_sync, csm_op_trap_async,
      csm_op_system_call, csm_op_call_return, csm_op_exception_return,
      csm_op_begin_service, csm_op_save_lower, csm_op_restore_lower,
      csm_op_store_lower, csm_op_store_upper, csm_op_load_lower,
      csm_op_load_upper
   } csm_op_type;
   typedef enum logic [2:0] {
      st_idle, st_prep, st_link, st_relink, st_relink_wait, st_body
   } csm_state_type;
endpackage : csm_pkg

// ---- design/csm_seq.sv ----
// Word sequencer: walks words first..last of one save area in order.
// Assumes memory answers each held request with a one-cycle ack.
module csm_seq
   import csm_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   csm_seq_if.seq s,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in
);
`include "csm_consts.svh"
   logic [3:0] idx;
   logic [3:0] last;

   ////////////////////////////////////////////////////////////////////////
   // One request held per word; the next word goes out on the ack edge
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= 32'h00000000;
         mem_wdata_out <= 32'h00000000;
         idx <= 4'h0;
         last <= 4'h0;
         s.ridx <= 4'h0;
         s.rvalid <= 1'b0;
         s.rdata <= 32'h00000000;
         s.done <= 1'b0;
      end else begin
         s.done <= 1'b0;
         s.rvalid <= 1'b0;
         if (!mem_req_out && s.start) begin
            mem_req_out <= 1'b1;
            mem_we_out <= s.wr;
            idx <= s.first;
            last <= s.last;
            mem_addr_out <= s.base + {26'h0, s.first, 2'h0};
            mem_wdata_out <= s.img[s.first];
         end else if (mem_req_out && mem_ack_in) begin
            s.rdata <= mem_rdata_in;
            s.ridx <= idx;
            s.rvalid <= !mem_we_out;
            if (idx == last) begin
               mem_req_out <= 1'b0;
               s.done <= 1'b1;
            end else begin
               idx <= idx + 4'h1;
               mem_addr_out <= mem_addr_out + `CSM_WORD_BYTES;
               mem_wdata_out <= s.img[idx + 4'h1];
            end
         end
      end
   end
endmodule : csm_seq

// ---- design/csm_seq_if.sv ----
// Carrier between the list manager and the word sequencer.
// Assumes both ends run on the same clock.
interface csm_seq_if;
   logic start;
   logic wr;
   logic [31:0] base;
   logic [3:0] first;
   logic [3:0] last;
   logic [31:0] img [16];
   logic [3:0] ridx;
   logic rvalid;
   logic [31:0] rdata;
   logic done;
   modport mgr(output start, wr, base, first, last, img, input ridx, rvalid, rdata, done);
   modport seq(input start, wr, base, first, last, img, output ridx, rvalid, rdata, done);
endinterface : csm_seq_if

// ---- testbench/csm_mem_model.sv ----
// Word memory model standing behind the manager's req/ack port.
// Assumes each request is held until its ack; lag_in adds wait states.
module csm_mem_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [1:0] lag_in,
   output logic ack_out,
   output logic [31:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [1024];
   logic [1:0] wait_cnt;
   ////////////////////////////////////////////////////////////////////////////
   // One-cycle ack; data is scrambled outside the ack so stale reads show up
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_out <= 1'b0;
         wait_cnt <= 2'h0;
         rdata_out <= 32'h5A5A5A5A;
      end else if (req_in && !ack_out && wait_cnt == lag_in) begin
         ack_out <= 1'b1;
         wait_cnt <= 2'h0;
         rdata_out <= mem[addr_in[11:2]];
         if (we_in) mem[addr_in[11:2]] <= wdata_in;
      end else begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         wait_cnt <= (req_in && !ack_out) ? wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule : csm_mem_model

// ---- testbench/tb.sv ----
// Bench for the context save list manager: saves, restores, traps, stores.
// Assumes the design files and csm_mem_model are compiled first.
module tb
   import csm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in, rst_in, op_valid_in, irq_enable_flag_in, cfg_wr_in, mem_ack_in;
   logic mem_req_out, mem_we_out, op_busy_out, op_done_out, ctx_valid_out, irq_reenable_out;
   logic free_list_depletion_trap_out, free_list_underflow_trap_out, context_type_error_out;
   logic call_stack_underflow_trap_out, call_depth_overflow_out;
   csm_op_type op_code_in;
   logic [31:0] op_pc_in, op_next_pc_in, op_ea_in, irq_stack_base_ptr_in, cfg_context_info_in;
   logic [31:0] cfg_status_in, cfg_stack_ptr_in, cfg_return_addr_in, mem_rdata_in;
   logic [31:0] mem_addr_out, mem_wdata_out, previous_context_info_out;
   logic [31:0] processor_status_word_out, stack_pointer_out, return_address_out;
   logic [31:0] ctx_img_in [16], ctx_img_out [16];
   logic [7:0] cur_cpu_priority_in;
   logic [19:0] cfg_free_head_in, cfg_free_limit_in, free_list_head_ptr_out;
   logic [1:0] lag;
   logic [5:0] fl;
   int err_total, compares;
   csm_manager u_dut (.*);
   csm_mem_model u_mem (.clk_in(sys_clk_in), .rst_in(rst_in), .req_in(mem_req_out),
      .we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .lag_in(lag),
      .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for done; trap pulses are gathered over the whole wait
   task automatic run(input csm_op_type c);
      int n;
      @(negedge sys_clk_in);
      op_code_in = c;
      op_valid_in = 1'b1;
      fl = 6'h00;
      @(negedge sys_clk_in);
      op_valid_in = 1'b0;
      for (n = 0; n < 300 && op_done_out !== 1'b1; n++) begin
         fl |= {free_list_depletion_trap_out, free_list_underflow_trap_out,
            context_type_error_out, irq_reenable_out, ctx_valid_out,
            call_stack_underflow_trap_out};
         @(negedge sys_clk_in);
      end
      fl |= {free_list_depletion_trap_out, free_list_underflow_trap_out,
         context_type_error_out, irq_reenable_out, ctx_valid_out,
         call_stack_underflow_trap_out};
      chk({31'h0, n < 300}, 32'h1);
   endtask : run
   task automatic results;
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   // Watchdog far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      err_total++;
      results();
   end
   initial begin
      {rst_in, cfg_wr_in, op_valid_in, lag, irq_enable_flag_in} = 6'h21;
      op_code_in = csm_op_call;
      {op_pc_in, op_next_pc_in} = {32'h1000, 32'h1004};
      {op_ea_in, irq_stack_base_ptr_in, cur_cpu_priority_in} = {32'h400, 32'h8000, 8'h05};
      {cfg_free_head_in, cfg_free_limit_in, cfg_context_info_in} = {20'h1, 20'h3, 32'h0};
      {cfg_status_in, cfg_stack_ptr_in, cfg_return_addr_in} = {32'h0, 32'h100, 32'h200};
      for (int i = 0; i < 16; i++) ctx_img_in[i] = 32'hC0 + i;
      {u_mem.mem[16], u_mem.mem[32], u_mem.mem[48]} = {32'h2, 32'h3, 32'h0};
      repeat (16) @(negedge sys_clk_in);
      rst_in = 1'b0;
      cfg_wr_in = 1'b1;
      @(negedge sys_clk_in);
      cfg_wr_in = 1'b0;
      run(csm_op_exception_return);
      chk(fl[0], 1'b1);
      run(csm_op_call);
      chk(free_list_head_ptr_out, 32'h2);
      chk(u_mem.mem[16], 32'h0);
      chk(u_mem.mem[19], 32'h200);
      chk(u_mem.mem[20], 32'hC4);
      chk(return_address_out, 32'h1004);
      chk(previous_context_info_out[20:0], 32'h100001);
      run(csm_op_restore_lower);
      chk({fl[3], free_list_head_ptr_out}, 32'h100002);
      run(csm_op_call_return);
      chk(free_list_head_ptr_out, 32'h1);
      chk(u_mem.mem[16], 32'h2);
      chk(return_address_out, 32'h200);
      chk(fl[1], 1'b1);
      chk(ctx_img_out[2], 32'h100);
      lag = 2'h2;
      run(csm_op_irq);
      chk(stack_pointer_out, 32'h8000);
      chk(processor_status_word_out[9], 1'b1);
      chk(previous_context_info_out[29:21], 9'h0B);
      chk(u_mem.mem[16], 32'h0);
      run(csm_op_begin_service);
      chk(fl[2], 1'b1);
      chk(u_mem.mem[33], 32'h1004);
      run(csm_op_save_lower);
      chk({fl[5], free_list_head_ptr_out}, 32'h100000);
      run(csm_op_call);
      chk(fl[4], 1'b1);
      run(csm_op_store_upper);
      chk(free_list_head_ptr_out, 32'h0);
      chk(u_mem.mem[258], 32'h8000);
      run(csm_op_load_lower);
      chk(fl[1], 1'b1);
      chk(ctx_img_out[2], 32'h8000);
      chk(return_address_out, 32'h200);
      chk(previous_context_info_out, 32'h01600003);
      chk(free_list_head_ptr_out, 32'h0);
      results();
   end
endmodule : tb
